// *** bench/decorated_field_extract_decode_bench.sv ***
`timescale 1ns/1ps

module decorated_field_extract_decode_bench;
    logic mclk, rst_b, mHwrite, mHreadyOut, mHresp, sHwrite, sHreadyIn, sHready, sHresp;
    logic [31:0] mHaddr, mHwdata, mHrdata, sHaddr, sHwdata, sHrdata;
    logic [1:0] mHtrans, sHtrans;
    logic [2:0] mHsize, sHsize;
    int mismatches = 0;
    int compares = 0;
    dfx_bridge dut_u (.mclk, .rst_b, .mHaddr, .mHtrans, .mHwrite, .mHsize, .mHwdata, .mHrdata,
        .mHreadyOut, .mHresp, .sHaddr, .sHtrans, .sHwrite, .sHsize, .sHwdata, .sHreadyIn,
        .sHrdata, .sHready, .sHresp);
    dfx_slave_model slv_u (.mclk, .sHaddr, .sHtrans, .sHwrite, .sHreadyIn, .sHrdata, .sHready,
        .sHresp);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] fx(input logic [31:0] d, input int sz, b, w);
        logic [63:0] c;
        c = {32'h0, d} & ((64'h1 << (8 << sz)) - 64'h1);
        return 32'((c >> b) & ((64'h1 << (w + 1)) - 64'h1));
    endfunction
    // one non-pipelined transfer, sampled just after the settling edge
    task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
            input logic [31:0] exp, input logic er);
        int n;
        @(negedge mclk);
        mHaddr = a;
        mHtrans = 2'h2;
        mHwrite = w;
        mHsize = sz;
        @(negedge mclk);
        mHtrans = 2'h0;
        mHwdata = ~a;
        #1;
        n = 0;
        while (mHreadyOut !== 1'b1 && n < 20) begin
            @(negedge mclk);
            #1;
            n++;
        end
        chk("resp ready", {30'h0, er, 1'b1}, {30'h0, mHresp, mHreadyOut});
        if (!w && !er) chk("rdata", exp, mHrdata);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_pass();
        int wc;
        slv_u.memWord = 32'h1234_5678;
        slv_u.waits = 2;
        xfer(32'h4000_1000, 1'b0, 3'h2, 32'h1234_5678, 1'b0);
        slv_u.waits = 0;
        wc = slv_u.writeCount;
        xfer(32'h400f_f008, 1'b1, 3'h2, 32'h0, 1'b0);
        chk("gpio addr", 32'h4000_f008, slv_u.lastAddr);
        chk("writes", wc + 1, slv_u.writeCount);
        $display("test_pass done");
    endtask
    task automatic test_extract();
        int t[6][3] = '{'{2, 0, 0}, '{2, 12, 15}, '{0, 6, 3}, '{1, 3, 4}, '{1, 20, 15},
            '{0, 7, 0}};
        int wc;
        logic [31:0] a;
        wc = slv_u.writeCount;
        slv_u.memWord = 32'hc3a5_9e71;
        foreach (t[i]) begin
            slv_u.waits = i % 2;
            a = 32'h5000_f000 | 32'(t[i][1] << 23) | 32'(t[i][2] << 19);
            xfer(a, 1'b0, 3'(t[i][0]), fx(32'hc3a5_9e71, t[i][0], t[i][1], t[i][2]), 1'b0);
        end
        xfer(32'h5118_f002, 1'b0, 3'h0, fx(32'h0000_c3a5, 0, 2, 3) << 16, 1'b0);
        chk("writes", wc, slv_u.writeCount);
        $display("test_extract done");
    endtask
    task automatic test_illegal();
        logic [31:0] bad[4] = '{32'h4008_0000, 32'h400f_effc, 32'h4010_0000, 32'h43ff_fffc};
        int wc;
        wc = slv_u.writeCount;
        foreach (bad[i]) xfer(bad[i], 1'(i % 2), 3'h2, 32'h0, 1'b1);
        chk("writes", wc, slv_u.writeCount);
        $display("test_illegal done");
    endtask
    task automatic test_decor();
        xfer(32'h4408_0004, 1'b1, 3'h2, 32'h0, 1'b0);
        chk("decor addr", 32'h4408_0004, slv_u.lastAddr);
        xfer(32'h5008_f010, 1'b1, 3'h2, 32'h0, 1'b0);
        chk("insert addr", 32'h5008_f010, slv_u.lastAddr);
        $display("test_decor done");
    endtask
    task automatic test_slave_err();
        slv_u.errMode = 1'b1;
        xfer(32'h4000_2000, 1'b0, 3'h2, 32'h0, 1'b1);
        xfer(32'h5000_f000, 1'b0, 3'h2, 32'h0, 1'b1);
        slv_u.errMode = 1'b0;
        xfer(32'h4000_2000, 1'b0, 3'h2, 32'hc3a5_9e71, 1'b0);
        $display("test_slave_err done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        mHaddr = 32'h0;
        mHtrans = 2'h0;
        mHwrite = 1'b0;
        mHsize = 3'h2;
        mHwdata = 32'h0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        test_pass();
        test_extract();
        test_illegal();
        test_decor();
        test_slave_err();
        summarize();
    end
    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        summarize();
    end
endmodule

// *** bench/dfx_bridge_assertions.sv ***
`timescale 1ns/1ps
`include "dfx_params.svh"

module dfx_bridge_assertions (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [31:0] mHaddr,
    input wire logic [1:0] mHtrans,
    input wire logic mHwrite,
    input wire logic [2:0] mHsize,
    input wire logic [31:0] mHwdata,
    input wire logic [31:0] mHrdata,
    input wire logic mHreadyOut,
    input wire logic mHresp,
    input wire logic [31:0] sHaddr,
    input wire logic [1:0] sHtrans,
    input wire logic sHwrite,
    input wire logic [2:0] sHsize,
    input wire logic [31:0] sHwdata,
    input wire logic sHreadyIn,
    input wire logic [31:0] sHrdata,
    input wire logic sHready,
    input wire logic sHresp
);
    logic take, ill, ext, norm, decor, passPhase_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    assign take = mHreadyOut && mHtrans[1];
    assign ill = take && ((mHaddr >= `DFX_ILL0_BASE && mHaddr <= `DFX_ILL0_LAST)
        || (mHaddr >= `DFX_ILL1_BASE && mHaddr <= `DFX_ILL1_LAST));
    assign ext = take && !mHwrite && mHaddr[31:28] == 4'h5;
    assign norm = take && mHaddr >= `DFX_PERIPH_BASE && mHaddr <= `DFX_PERIPH_LAST;
    assign decor = take && mHaddr >= `DFX_DECOR_BASE && mHaddr <= `DFX_DECOR_LAST;
    ////////////////////////////////////////////////////////////////////////////
    // marks the data phase of a plain peripheral transfer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            passPhase_reg <= 1'b0;
        end else if (mHreadyOut) begin
            passPhase_reg <= norm;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    wdata_pass_a: assert property (sHwdata == mHwdata)
        else $error("write data not forwarded");
    norm_fwd_a: assert property (norm |-> sHaddr == mHaddr && sHtrans == mHtrans)
        else $error("plain transfer altered");
    pass_data_a: assert property (passPhase_reg |-> mHreadyOut == sHready
        && mHrdata == sHrdata && mHresp == sHresp) else $error("data phase not passed");
    gpio_alias_a: assert property (take && mHaddr[31:12] == 20'h400ff
        |-> sHaddr == {20'h4000f, mHaddr[11:0]}) else $error("gpio slot not aliased");
    ill_block_a: assert property (ill |-> sHtrans == `DFX_TRANS_IDLE)
        else $error("illegal access forwarded");
    ill_error_a: assert property (ill |=> !mHreadyOut && mHresp ##1 mHreadyOut && mHresp)
        else $error("illegal access not error terminated");
    ext_addr_a: assert property (ext |-> !sHwrite
        && sHaddr == (`DFX_PERIPH_BASE | {13'h0, mHaddr[18:0]})) else $error("extract address");
    ext_stall_a: assert property (ext |=> !mHreadyOut && sHtrans == `DFX_TRANS_IDLE)
        else $error("extract not stalled or wrote back");
    ext_return_a: assert property (ext ##1 (sHready && !sHresp) |=> mHreadyOut && !mHresp)
        else $error("extract return late");
    decor_fwd_a: assert property (decor |-> sHaddr == mHaddr)
        else $error("decorated address altered");
    size_pass_a: assert property (sHsize == mHsize)
        else $error("transfer size not forwarded");
    ready_in_a: assert property (passPhase_reg |-> sHreadyIn == sHready)
        else $error("slave ready not passed back");
    insert_fwd_a: assert property (take && mHwrite && mHaddr[31:28] == 4'h5
        |-> sHaddr == mHaddr) else $error("insert address altered");
endmodule

bind dfx_bridge dfx_bridge_assertions chk_u (.mclk, .rst_b, .mHaddr, .mHtrans, .mHwrite,
    .mHsize, .mHwdata, .mHrdata, .mHreadyOut, .mHresp, .sHaddr, .sHtrans, .sHwrite, .sHsize,
    .sHwdata, .sHreadyIn, .sHrdata, .sHready, .sHresp);

// *** bench/dfx_slave_model.sv ***
`timescale 1ns/1ps

module dfx_slave_model (
    input wire logic mclk,
    input wire logic [31:0] sHaddr,
    input wire logic [1:0] sHtrans,
    input wire logic sHwrite,
    input wire logic sHreadyIn,
    output logic [31:0] sHrdata,
    output logic sHready,
    output logic sHresp
);
    logic [31:0] memWord = 32'h0;
    logic [31:0] lastAddr = 32'h0;
    logic busy = 1'b0;
    logic errMode = 1'b0;
    int waits = 0;
    int writeCount = 0;
    int cnt = 0;
    // wait states stretch the data phase
    always @(posedge mclk) begin
        if (sHreadyIn) begin
            busy <= sHtrans[1];
            cnt <= errMode ? 1 : waits;
            if (sHtrans[1]) lastAddr <= sHaddr;
            if (sHtrans[1] && sHwrite) writeCount <= writeCount + 1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign sHready = !(busy && cnt > 0);
    // outside the answer cycle the data lines show the inverse
    assign sHrdata = (sHready && busy) ? memWord : ~memWord;
    // error answer: one cycle not ready with error, then ready with error
    assign sHresp = busy && errMode;
endmodule

// *** rtl/dfx_bridge.sv ***
`timescale 1ns/1ps
`include "dfx_params.svh"


module dfx_bridge (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [31:0] mHaddr,
    input wire logic [1:0] mHtrans,
    input wire logic mHwrite,
    input wire logic [2:0] mHsize,
    input wire logic [31:0] mHwdata,
    output logic [31:0] mHrdata,
    output logic mHreadyOut,
    output logic mHresp,
    output logic [31:0] sHaddr,
    output logic [1:0] sHtrans,
    output logic sHwrite,
    output logic [2:0] sHsize,
    output logic [31:0] sHwdata,
    output logic sHreadyIn,
    input wire logic [31:0] sHrdata,
    input wire logic sHready,
    input wire logic sHresp
);

    dfx_pkg::dfx_state_type stateReg;
    dfx_pkg::dfx_state_type stateNext;
    dfx_pkg::dfx_rst_type rstReg;
    dfx_pkg::dfx_rst_type rstNext;
    logic rstN;
    logic isExtract;
    logic forward;
    dfx_dec_if dec ();

    dfx_field_unit fieldUnit (
        .dec(dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    always_comb begin
        rstNext.rstSync = {rstReg.rstSync[0], 1'b1};
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstReg <= '0;
        end else begin
            rstReg <= rstNext;
        end
    end

    assign rstN = rstReg.rstSync[1];

    ////////////////////////////////////////////////////////////////////////////
    // decode hookup
    always_comb begin
        dec.addr = mHaddr;
        dec.size = mHsize;
        dec.rdata = sHrdata;
        dec.bitPosReg = stateReg.bitPos;
        dec.widthReg = stateReg.widthM1;
        dec.laneReg = stateReg.lane;
        dec.sizeReg = stateReg.size;
    end

    assign isExtract = (dec.kind == dfx_pkg::DFX_CLS_FIELD) && !mHwrite;
    assign forward = (dec.kind != dfx_pkg::DFX_CLS_ILLEGAL);

    ////////////////////////////////////////////////////////////////////////////
    // master side answer
    always_comb begin
        mHreadyOut = 1'b1;
        mHresp = 1'b0;
        mHrdata = sHrdata;
        sHreadyIn = 1'b1;
        unique case (stateReg.phase)
            dfx_pkg::DFX_PH_PASS: begin
                mHreadyOut = sHready;
                mHresp = sHresp;
                sHreadyIn = sHready;
            end
            dfx_pkg::DFX_PH_EXT_DATA: begin
                mHreadyOut = sHresp & sHready;
                mHresp = sHresp;
                sHreadyIn = sHready;
            end
            dfx_pkg::DFX_PH_EXT_RET: begin
                mHrdata = (stateReg.data >> stateReg.bitPos) << stateReg.lane;
            end
            dfx_pkg::DFX_PH_ERR_FIRST: begin
                mHreadyOut = 1'b0;
                mHresp = 1'b1;
                sHreadyIn = 1'b0;
            end
            dfx_pkg::DFX_PH_ERR_LAST: begin
                mHresp = 1'b1;
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // slave side address phase
    always_comb begin
        if (dec.kind == dfx_pkg::DFX_CLS_FIELD && mHwrite) begin
            sHaddr = mHaddr;
        end else begin
            sHaddr = dec.memAddr;
        end
        sHwrite = mHwrite;
        sHsize = mHsize;
        sHwdata = mHwdata;
        if (mHreadyOut && forward) begin
            sHtrans = mHtrans;
        end else begin
            sHtrans = `DFX_TRANS_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencing
    always_comb begin
        stateNext = stateReg;
        unique case (stateReg.phase)
            dfx_pkg::DFX_PH_EXT_DATA: begin
                if (sHready && !sHresp) begin
                    stateNext.data = dec.masked;
                    stateNext.phase = dfx_pkg::DFX_PH_EXT_RET;
                end
            end
            dfx_pkg::DFX_PH_ERR_FIRST: begin
                stateNext.phase = dfx_pkg::DFX_PH_ERR_LAST;
            end
            default: begin
            end
        endcase
        if (mHreadyOut) begin
            if (!mHtrans[1]) begin
                stateNext.phase = dfx_pkg::DFX_PH_IDLE;
            end else if (!forward) begin
                stateNext.phase = dfx_pkg::DFX_PH_ERR_FIRST;
            end else if (isExtract) begin
                stateNext.phase = dfx_pkg::DFX_PH_EXT_DATA;
                stateNext.bitPos = dec.bitPos;
                stateNext.widthM1 = dec.widthM1;
                stateNext.lane = dec.lane;
                stateNext.size = mHsize;
            end else begin
                stateNext.phase = dfx_pkg::DFX_PH_PASS;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

endmodule

// *** rtl/dfx_dec_if.sv ***
`timescale 1ns/1ps

interface dfx_dec_if;
    logic [31:0] addr;
    logic [2:0] size;
    logic [31:0] rdata;
    logic [4:0] bitPosReg;
    logic [3:0] widthReg;
    logic [4:0] laneReg;
    logic [2:0] sizeReg;
    dfx_pkg::dfx_class_type kind;
    logic [31:0] memAddr;
    logic [4:0] bitPos;
    logic [3:0] widthM1;
    logic [4:0] lane;
    logic [31:0] masked;

    modport unit (
        input addr, size, rdata, bitPosReg, widthReg, laneReg, sizeReg,
        output kind, memAddr, bitPos, widthM1, lane, masked
    );
    modport core (
        output addr, size, rdata, bitPosReg, widthReg, laneReg, sizeReg,
        input kind, memAddr, bitPos, widthM1, lane, masked
    );
endinterface

// *** rtl/dfx_field_unit.sv ***
`timescale 1ns/1ps
`include "dfx_params.svh"

module dfx_field_unit (
    dfx_dec_if.unit dec
);

    ////////////////////////////////////////////////////////////////////////////
    // address classification
    function automatic dfx_pkg::dfx_class_type classify(input logic [31:0] a);
        if (a >= `DFX_PERIPH_BASE && a <= `DFX_PERIPH_LAST) begin
            classify = dfx_pkg::DFX_CLS_NORMAL;
        end else if (a >= `DFX_GPIO_STD_BASE && a <= `DFX_GPIO_STD_LAST) begin
            classify = dfx_pkg::DFX_CLS_GPIO;
        end else if ((a >= `DFX_ILL0_BASE && a <= `DFX_ILL0_LAST) ||
                     (a >= `DFX_ILL1_BASE && a <= `DFX_ILL1_LAST)) begin
            classify = dfx_pkg::DFX_CLS_ILLEGAL;
        end else if (a >= `DFX_DECOR_BASE && a <= `DFX_DECOR_LAST) begin
            classify = dfx_pkg::DFX_CLS_DECOR;
        end else if (a >= `DFX_FIELD_BASE && a <= `DFX_FIELD_LAST &&
                     a[`DFX_REGION_MSB:`DFX_REGION_LSB] == `DFX_REGION_PERIPH &&
                     a[`DFX_EXTRACT_BIT]) begin
            classify = dfx_pkg::DFX_CLS_FIELD;
        end else begin
            classify = dfx_pkg::DFX_CLS_OUTSIDE;
        end
    endfunction

    // container follows the access size
    function automatic logic [31:0] container(input logic [2:0] sz);
        if (sz == `DFX_SIZE_BYTE) begin
            container = `DFX_MASK_BYTE;
        end else if (sz == `DFX_SIZE_HALF) begin
            container = `DFX_MASK_HALF;
        end else begin
            container = `DFX_MASK_WORD;
        end
    endfunction

    logic [31:0] fieldMask;
    logic [4:0] widthCount;

    ////////////////////////////////////////////////////////////////////////////
    // address phase decode
    always_comb begin
        dec.kind = classify(dec.addr);
        dec.bitPos = dec.addr[`DFX_BPOS_MSB:`DFX_BPOS_LSB];
        dec.widthM1 = dec.addr[`DFX_WIDTH_MSB:`DFX_WIDTH_LSB];
        unique case (dec.kind)
            dfx_pkg::DFX_CLS_FIELD: begin
                dec.memAddr = `DFX_PERIPH_BASE | {13'h0, dec.addr[`DFX_OFFS_MSB:0]};
            end
            dfx_pkg::DFX_CLS_GPIO: begin
                dec.memAddr = `DFX_GPIO_ALT_BASE | {20'h0, dec.addr[`DFX_SLOT_MSB:0]};
            end
            default: begin
                dec.memAddr = dec.addr;
            end
        endcase
        if (dec.size == `DFX_SIZE_BYTE) begin
            dec.lane = {dec.addr[1:0], 3'h0};
        end else if (dec.size == `DFX_SIZE_HALF) begin
            dec.lane = {dec.addr[1], 4'h0};
        end else begin
            dec.lane = 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data phase mask, clipped at the container edge
    always_comb begin
        widthCount = {1'b0, dec.widthReg} + 5'h01;
        fieldMask = ((32'h0000_0001 << widthCount) - 32'h0000_0001) << dec.bitPosReg;
        dec.masked = (dec.rdata >> dec.laneReg) & fieldMask & container(dec.sizeReg);
    end

endmodule

// *** rtl/dfx_params.svh ***
`ifndef DFX_PARAMS_SVH
`define DFX_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// peripheral map
`define DFX_PERIPH_BASE 32'h4000_0000
`define DFX_PERIPH_LAST 32'h4007_ffff
`define DFX_ILL0_BASE 32'h4008_0000
`define DFX_ILL0_LAST 32'h400f_efff
`define DFX_GPIO_STD_BASE 32'h400f_f000
`define DFX_GPIO_STD_LAST 32'h400f_ffff
`define DFX_GPIO_ALT_BASE 32'h4000_f000
`define DFX_ILL1_BASE 32'h4010_0000
`define DFX_ILL1_LAST 32'h43ff_ffff
`define DFX_DECOR_BASE 32'h4400_0000
`define DFX_DECOR_LAST 32'h4fff_ffff
`define DFX_FIELD_BASE 32'h5000_0000
`define DFX_FIELD_LAST 32'h5fff_ffff
`define DFX_SLOT_COUNT 129
`define DFX_SLOT_MSB 11

////////////////////////////////////////////////////////////////////////////////
// decoration fields
`define DFX_REGION_MSB 30
`define DFX_REGION_LSB 29
`define DFX_REGION_PERIPH 2'h2
`define DFX_EXTRACT_BIT 28
`define DFX_BPOS_MSB 27
`define DFX_BPOS_LSB 23
`define DFX_WIDTH_MSB 22
`define DFX_WIDTH_LSB 19
`define DFX_OFFS_MSB 18

////////////////////////////////////////////////////////////////////////////////
// bus encodings
`define DFX_TRANS_IDLE 2'h0
`define DFX_SIZE_BYTE 3'h0
`define DFX_SIZE_HALF 3'h1
`define DFX_MASK_BYTE 32'h0000_00ff
`define DFX_MASK_HALF 32'h0000_ffff
`define DFX_MASK_WORD 32'hffff_ffff

`endif

// *** rtl/dfx_pkg.sv ***
package dfx_pkg;

    typedef enum logic [2:0] {
        DFX_CLS_OUTSIDE = 3'b000,
        DFX_CLS_NORMAL = 3'b001,
        DFX_CLS_GPIO = 3'b010,
        DFX_CLS_DECOR = 3'b011,
        DFX_CLS_FIELD = 3'b100,
        DFX_CLS_ILLEGAL = 3'b101
    } dfx_class_type;

    typedef enum logic [2:0] {
        DFX_PH_IDLE = 3'b000,
        DFX_PH_PASS = 3'b001,
        DFX_PH_EXT_DATA = 3'b010,
        DFX_PH_EXT_RET = 3'b011,
        DFX_PH_ERR_FIRST = 3'b100,
        DFX_PH_ERR_LAST = 3'b101
    } dfx_phase_type;

    typedef struct packed {
        dfx_phase_type phase;
        logic [4:0] bitPos;
        logic [3:0] widthM1;
        logic [4:0] lane;
        logic [2:0] size;
        logic [31:0] data;
    } dfx_state_type;

    typedef struct packed {
        logic [1:0] rstSync;
    } dfx_rst_type;

endpackage
